// File: sdmrb_top.sv
`timescale 1ns/1ps
module sdmrb_top #(
  parameter int DEPTH = sdmrb_pkg::FIFO_DEPTH
) (
  input wire logic mclk, // system clock, 125 MHz
  input wire logic rst, // async reset, active high
  input wire logic cs_n, // chip select, low active
  input wire logic ras_n, // row strobe, low active
  input wire logic cas_n, // column strobe, low active
  input wire logic we_n, // write enable, low active
  input wire logic [sdmrb_pkg::ADDR_W-1:0] addr, // address inputs
  output logic [sdmrb_pkg::WORD_W-1:0] mode_word, // stored settings word
  output logic col_valid, // column access available
  input wire logic col_ready, // array side takes column
  output logic [sdmrb_pkg::COL_W-1:0] col_addr, // column being accessed
  output logic col_is_write, // column belongs to a write burst
  output logic dq_drive, // data outputs driving
  output logic dq_valid, // one-cycle pulse at the first read data valid edge
  output logic burst_active, // sequencer busy
  output logic normal_mode // op select bits both zero
);
  import sdmrb_pkg::*;

  typedef enum logic [1:0] {
    SDMRB_IDLE = 2'b01,
    SDMRB_RUN = 2'b10
  } sdmrb_state_t;

  logic [WORD_W-1:0] mode_q, mode_d;
  sdmrb_state_t st_q, st_d;
  logic [COL_W-1:0] start_q, start_d;
  logic [10:0] idx_q, idx_d, len_q, len_d;
  logic wr_q, wr_d, ilv_q, ilv_d;
  logic [3:0] rd_pipe_q, rd_pipe_d;
  logic [3:0] cmd;
  logic is_load, is_read, is_write, is_term, stall;
  logic [2:0] bl_f, rl_f;
  logic [COL_W-1:0] cur_col;
  sdmrb_col_if #(.W(COL_W + 1)) seq_if ();
  sdmrb_col_if #(.W(COL_W + 1)) out_if ();

  // burst length decode; reserved codes and interleaved full page fall back to one
  function automatic logic [10:0] burst_len(input logic [2:0] code, input logic ilv);
    case (code)
      BL_1: burst_len = 11'h001;
      BL_2: burst_len = 11'h002;
      BL_4: burst_len = 11'h004;
      BL_8: burst_len = 11'h008;
      BL_PAGE: burst_len = ilv ? 11'h001 : PAGE_LEN;
      default: burst_len = 11'h001;
    endcase
  endfunction

  // column of access i: upper bits hold the block, low bits wrap inside it
  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] st,
      input logic [10:0] i, input logic [10:0] len, input logic ilv);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] lo;
    mask = '0;
    lo = '0;
    mask = len[COL_W-1:0] - 1'b1; // full page yields all ones
    if (ilv) begin
      lo = st ^ i[COL_W-1:0];
    end else begin
      lo = st + i[COL_W-1:0];
    end
    col_of = (st & ~mask) | (lo & mask);
  endfunction

  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign is_load = (cmd == CMD_LOAD);
  assign is_read = (cmd == CMD_READ);
  assign is_write = (cmd == CMD_WRITE);
  assign is_term = (cmd == CMD_TERM);
  assign bl_f = mode_q[BL_LSB +: 3];
  assign rl_f = mode_q[RL_LSB +: 3];
  assign stall = !seq_if.ready; // fifo full holds the sequencer

  // mode word: only bits 0-11 are taken; bit 12 stays zero since it is undefined
  always_comb begin
    mode_d = mode_q;
    if (is_load) begin
      mode_d = {1'b0, addr[11:0]};
    end
  end

  // burst sequencer; a new read or write restarts, terminate ends early
  always_comb begin
    st_d = st_q;
    start_d = start_q;
    idx_d = idx_q;
    len_d = len_q;
    wr_d = wr_q;
    ilv_d = ilv_q;
    if (is_read || is_write) begin
      st_d = SDMRB_RUN;
      start_d = addr[COL_W-1:0];
      idx_d = '0;
      wr_d = is_write;
      ilv_d = mode_q[BO_BIT] && (bl_f != BL_1);
      if (is_write && mode_q[WB_BIT]) begin
        len_d = 11'h001;
      end else begin
        len_d = burst_len(bl_f, mode_q[BO_BIT]);
      end
    end else if (is_term) begin
      st_d = SDMRB_IDLE;
    end else begin
      case (st_q)
        SDMRB_IDLE: st_d = SDMRB_IDLE;
        SDMRB_RUN: begin
          if (!stall) begin
            idx_d = idx_q + 1'b1;
            if (idx_q + 1'b1 == len_q) begin
              st_d = SDMRB_IDLE;
            end
          end
        end
        default: st_d = SDMRB_IDLE;
      endcase
    end
  end

  // read latency pipe: bit k holds a read registered k edges before the latest edge
  always_comb begin
    rd_pipe_d = {rd_pipe_q[2:0], is_read};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_RST;
      st_q <= SDMRB_IDLE;
      start_q <= '0;
      idx_q <= '0;
      len_q <= 11'h001;
      wr_q <= 1'b0;
      ilv_q <= 1'b0;
      rd_pipe_q <= 4'h0;
    end else begin
      mode_q <= mode_d;
      st_q <= st_d;
      start_q <= start_d;
      idx_q <= idx_d;
      len_q <= len_d;
      wr_q <= wr_d;
      ilv_q <= ilv_d;
      rd_pipe_q <= rd_pipe_d;
    end
  end

  assign cur_col = col_of(start_q, idx_q, len_q, ilv_q);
  assign seq_if.valid = (st_q == SDMRB_RUN);
  assign seq_if.data = {wr_q, cur_col};

  sdmrb_fifo #(.W(COL_W + 1), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_p(seq_if),
    .out_p(out_if)
  );

  assign out_if.ready = col_ready;
  assign col_valid = out_if.valid;
  assign col_addr = out_if.data[COL_W-1:0];
  assign col_is_write = out_if.data[COL_W];
  assign mode_word = mode_q;
  assign burst_active = (st_q == SDMRB_RUN);
  assign normal_mode = !mode_q[OP_LO_BIT] && !mode_q[OP_HI_BIT];

  // drive rises after edge n+m-1, valid after edge n+m; reserved codes act as three
  always_comb begin
    if (rl_f == RL_2) begin
      dq_drive = rd_pipe_q[1];
      dq_valid = rd_pipe_q[2];
    end else begin
      dq_drive = rd_pipe_q[2];
      dq_valid = rd_pipe_q[3];
    end
  end

  // stored word: held between loads, bits 0-11 taken from the pins on a load

  property p_mode_hold;
    @(posedge mclk) disable iff (rst) !is_load |=> mode_q == $past(mode_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode word changed");

  property p_mode_load;
    @(posedge mclk) disable iff (rst) is_load |=> mode_q[11:0] == $past(addr[11:0]);
  endproperty
  a_mode_load: assert property (p_mode_load) else $error("load not stored");

  // read latency: a load in flight would change the mux, so those cases are left out
  property p_lat2;
    @(posedge mclk) disable iff (rst)
      (is_read && rl_f == RL_2 && !is_load) ##1 (!is_load) [*2] |-> dq_drive ##1 dq_valid;
  endproperty
  a_lat2: assert property (p_lat2) else $error("latency two wrong");

  property p_lat3;
    @(posedge mclk) disable iff (rst)
      (is_read && rl_f == RL_3 && !is_load) ##1 (!is_load) [*3] |-> dq_drive ##1 dq_valid;
  endproperty
  a_lat3: assert property (p_lat3) else $error("latency three wrong");

  // burst length and write burst mode
  property p_single_write;
    @(posedge mclk) disable iff (rst)
      (is_write && mode_q[WB_BIT]) |=> len_q == 11'h001;
  endproperty
  a_single_write: assert property (p_single_write) else $error("write not single");

  // column order: block bits fixed, low bits counted or xored
  property p_block_stay;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && len_q == 11'h008) |-> cur_col[9:3] == start_q[9:3];
  endproperty
  a_block_stay: assert property (p_block_stay) else $error("left block");

  property p_len1_exact;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && len_q == 11'h001) |-> cur_col == start_q;
  endproperty
  a_len1_exact: assert property (p_len1_exact) else $error("length one moved");

  property p_ilv;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && ilv_q && len_q == 11'h004) |->
        cur_col[1:0] == (start_q[1:0] ^ idx_q[1:0]);
  endproperty
  a_ilv: assert property (p_ilv) else $error("interleave order");

  property p_seq;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && !ilv_q && len_q == 11'h004) |->
        cur_col[1:0] == start_q[1:0] + idx_q[1:0];
  endproperty
  a_seq: assert property (p_seq) else $error("sequential order");

  // mode flag judged against the pins loaded, not against the stored word
  property p_normal;
    @(posedge mclk) disable iff (rst)
      is_load |=> normal_mode == ($past(addr[8:7]) == 2'b00);
  endproperty
  a_normal: assert property (p_normal) else $error("mode decode");

  // more order checks: short blocks and the full page
  property p_blk2;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && len_q == 11'h002) |-> cur_col[9:1] == start_q[9:1];
  endproperty
  a_blk2: assert property (p_blk2) else $error("left block of two");

  property p_blk4;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && len_q == 11'h004) |-> cur_col[9:2] == start_q[9:2];
  endproperty
  a_blk4: assert property (p_blk4) else $error("left block of four");

  property p_page_step;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && len_q == PAGE_LEN) |-> cur_col == start_q + idx_q[COL_W-1:0];
  endproperty
  a_page_step: assert property (p_page_step) else $error("page order");

  property p_page_seq;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN && len_q == PAGE_LEN) |-> !ilv_q;
  endproperty
  a_page_seq: assert property (p_page_seq) else $error("interleaved page");

  // first access of every burst is the start column in either order
  property p_first_col;
    @(posedge mclk) disable iff (rst)
      (is_read || is_write) |=> cur_col == $past(addr[COL_W-1:0]);
  endproperty
  a_first_col: assert property (p_first_col) else $error("first column");

  // sequencer bookkeeping: never past the programmed length, stops on terminate
  property p_run_end;
    @(posedge mclk) disable iff (rst)
      (st_q == SDMRB_RUN) |-> idx_q < len_q;
  endproperty
  a_run_end: assert property (p_run_end) else $error("burst overran");

  property p_term_stop;
    @(posedge mclk) disable iff (rst)
      is_term |=> !burst_active;
  endproperty
  a_term_stop: assert property (p_term_stop) else $error("terminate ignored");

  property p_wr_burst;
    @(posedge mclk) disable iff (rst)
      (is_write && !mode_q[WB_BIT] && bl_f == BL_8) |=> len_q == 11'h008;
  endproperty
  a_wr_burst: assert property (p_wr_burst) else $error("write burst length");

  // covers for the main scenarios
  c_read: cover property (@(posedge mclk) disable iff (rst) is_read ##3 dq_valid);
  c_page: cover property (@(posedge mclk) disable iff (rst) st_q == SDMRB_RUN && len_q == PAGE_LEN);
  c_full: cover property (@(posedge mclk) disable iff (rst) !seq_if.ready);
  c_term: cover property (@(posedge mclk) disable iff (rst) st_q == SDMRB_RUN && is_term);
endmodule

// File: sdmrb_pkg.sv
package sdmrb_pkg;
  localparam int COL_W = 10;
  localparam int ADDR_W = 13;
  localparam int WORD_W = 13;
  localparam int BL_LSB = 0;
  localparam int BO_BIT = 3;
  localparam int RL_LSB = 4;
  localparam int OP_LO_BIT = 7;
  localparam int OP_HI_BIT = 8;
  localparam int WB_BIT = 9;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] RL_2 = 3'h2;
  localparam logic [2:0] RL_3 = 3'h3;
  localparam logic [10:0] PAGE_LEN = 11'h400;
  localparam logic [WORD_W-1:0] MODE_RST = 13'h0032;
  // command encodings as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LOAD = 4'h0;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERM = 4'h6;
  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 16;
endpackage

// File: sdmrb_col_if.sv
`timescale 1ns/1ps
// column address stream from sequencer into fifo and out
interface sdmrb_col_if #(parameter int W = 12);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: sdmrb_fifo.sv
`timescale 1ns/1ps
// small synchronous fifo, full and empty honest, back-pressure via ready
module sdmrb_fifo #(
  parameter int W = 12,
  parameter int DEPTH = 8
) (
  input wire logic mclk, // clock
  input wire logic rst, // async reset, high
  sdmrb_col_if.snk in_p, // fill side
  sdmrb_col_if.src out_p // drain side
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic full, empty, push, pop;

  // pointers carry one extra bit to tell full from empty
  always_comb begin
    full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    empty = (wp_q == rp_q);
    push = in_p.valid && !full;
    pop = out_p.ready && !empty;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end
  assign in_p.ready = !full;
  assign out_p.valid = !empty;
  assign out_p.data = mem_q[rp_q[AW-1:0]];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  // storage has no reset; empty flag guards reads
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_p.data;
    end
  end
endmodule

// File: sdmrb_ctrl_model.sv
`timescale 1ns/1ps
// controller stand-in: one command per call, deselected in between
module sdmrb_ctrl_model (
  input wire logic mclk, // system clock
  output logic cs_n, // chip select, low active
  output logic ras_n, // row strobe, low active
  output logic cas_n, // column strobe, low active
  output logic we_n, // write enable, low active
  output logic [sdmrb_pkg::ADDR_W-1:0] addr // address inputs
);
  // idle: deselected, address inverted so stale values never look valid
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    addr = 13'h1FFF;
  end
  // loads come only after reset and between bursts, so banks sit idle
  task automatic issue(input logic [3:0] cmd, input logic [11:0] a);
    @(posedge mclk);
    {cs_n, ras_n, cas_n, we_n} <= cmd;
    addr <= {1'b0, a};
    @(posedge mclk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    addr <= {1'b0, ~a};
  endtask
endmodule

// File: tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
  import sdmrb_pkg::*;
  logic mclk, rst, cs_n, ras_n, cas_n, we_n, col_ready;
  logic [ADDR_W-1:0] addr;
  logic [WORD_W-1:0] mode_word;
  logic [COL_W-1:0] col_addr;
  logic col_valid, col_is_write, dq_drive, dq_valid, burst_active, normal_mode;
  int num_errors = 0;
  int n_checks = 0;
  sdmrb_ctrl_model ctl (.mclk(mclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .addr(addr));
  sdmrb_top #(.DEPTH(FIFO_DEPTH)) dut (.mclk(mclk), .rst(rst), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .mode_word(mode_word), .col_valid(col_valid),
    .col_ready(col_ready), .col_addr(col_addr), .col_is_write(col_is_write),
    .dq_drive(dq_drive), .dq_valid(dq_valid), .burst_active(burst_active),
    .normal_mode(normal_mode));
  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // expected column: block bits kept, low bits counted or xored within the block
  function automatic logic [9:0] exp_col(logic [9:0] s, int i, int len, logic ilv);
    logic [9:0] m;
    m = 10'(len - 1);
    if (ilv) return (s & ~m) | ((s ^ 10'(i)) & m);
    return (s & ~m) | ((s + 10'(i)) & m);
  endfunction
  task automatic load(input logic [11:0] m);
    ctl.issue(CMD_LOAD, m);
    @(negedge mclk);
    `CHK(mode_word, {1'b0, m})
    `CHK(normal_mode, m[8:7] == 2'h0)
  endtask
  // drain side stalls 12 cycles so bursts of eight or more fill the fifo, then takes every column
  task automatic burst(input logic [11:0] m, input logic [3:0] cmd, input logic [9:0] s,
    input int len);
    int got = 0;
    int t = 0;
    load(m);
    @(posedge mclk);
    col_ready <= 1'b0;
    ctl.issue(cmd, {2'h0, s});
    @(negedge mclk);
    `CHK(burst_active, 1'b1)
    repeat (12) @(posedge mclk);
    `CHK(burst_active, len > FIFO_DEPTH)
    col_ready <= 1'b1;
    while (got < len) begin
      @(negedge mclk);
      if (col_valid === 1'b1) begin
        `CHK(col_addr, exp_col(s, got, len, m[3]))
        `CHK(col_is_write, cmd == CMD_WRITE)
        got++;
      end
      t++;
      if (t > len + 40) begin
        num_errors++;
        conclude();
      end
    end
    repeat (10) begin
      @(negedge mclk);
      `CHK(col_valid, 1'b0)
    end
    `CHK(mode_word, {1'b0, m})
  endtask
  // page read cut by terminate one deselected cycle after it: two columns pushed, the page wraps
  task automatic trunc(input logic [9:0] s);
    int got = 0;
    load(12'h037);
    @(posedge mclk);
    col_ready <= 1'b0;
    ctl.issue(CMD_READ, {2'h0, s});
    ctl.issue(CMD_TERM, 12'h000);
    @(negedge mclk);
    `CHK(burst_active, 1'b0)
    @(posedge mclk);
    col_ready <= 1'b1;
    repeat (12) begin
      @(negedge mclk);
      if (col_valid === 1'b1) begin
        `CHK(col_addr, 10'(s + 10'(got)))
        got++;
      end
    end
    `CHK(got, 2)
  endtask
  // read at edge n: drive after edge n+m-1, valid after edge n+m
  // latency two only probes the decode; bursts all run latency three at this clock
  task automatic lat(input int m);
    load({5'h00, 3'(m), 4'h0});
    ctl.issue(CMD_READ, 12'h005);
    for (int k = 0; k < 5; k++) begin
      @(negedge mclk);
      `CHK(dq_drive, k == m - 1)
      `CHK(dq_valid, k == m)
    end
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    col_ready = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK(mode_word, MODE_RST)
    `CHK(normal_mode, 1'b1)
    // test-mode codes only probe the flag; no burst ever runs under them
    load(12'h0B0);
    load(12'h130);
    burst(12'h031, CMD_READ, 10'h001, 2);
    burst(12'h032, CMD_READ, 10'h00D, 4);
    burst(12'h03A, CMD_READ, 10'h00D, 4);
    burst(12'h033, CMD_READ, 10'h3FD, 8);
    burst(12'h03B, CMD_WRITE, 10'h125, 8);
    burst(12'h038, CMD_READ, 10'h123, 1);
    burst(12'h233, CMD_WRITE, 10'h00A, 1);
    burst(12'h233, CMD_READ, 10'h00A, 8);
    burst(12'h03A, CMD_WRITE, 10'h2C6, 4);
    burst(12'h037, CMD_READ, 10'h3FE, 1024);
    trunc(10'h3FF);
    lat(2);
    lat(3);
    conclude();
  end
endmodule
